/* File: core/dchpg_consts.svh */
// constants of the dual channel host port gate: offsets, bits, codes, resets
// Notes on behaviour
// - port enable bit claims host lines
// - ch1 read: output data or status
// - ch1 write: load input, command/data tag
// - ch2 read: output data or status
// - ch2 write: load input, command/data tag
// - fast gate enable bit selects hardware gating
// - firmware copies gate bit when not fast
// - direction bit one makes gate an output
// - gate pin starts at logic one
// - only channel 1 writes feed decoder
// - command D1 arms, next data drives gate
// - gate follows data bit 1 at strobe rise
// - D1, data, FF keep flag clear
// - other command cancels; repeated D1 re-arms
// - irq when enable set and buffer full
// - input full set by host, cleared by slave
// - output full set by slave, cleared by host
// - capture data and address at strobe rise
`ifndef DCHPG_CONSTS_SVH
`define DCHPG_CONSTS_SVH

// --------------------------------------------------------------------------
// register byte addresses
// --------------------------------------------------------------------------
`define DCHPG_ADDR_SYS_CTRL 16'h0000
`define DCHPG_ADDR_IRQ_EN 16'h0004
`define DCHPG_ADDR_GATE_PORT 16'h0008
`define DCHPG_ADDR_C1_IDATA 16'h0010
`define DCHPG_ADDR_C1_ODATA 16'h0014
`define DCHPG_ADDR_C1_STATUS 16'h0018
`define DCHPG_ADDR_C2_IDATA 16'h0020
`define DCHPG_ADDR_C2_ODATA 16'h0024
`define DCHPG_ADDR_C2_STATUS 16'h0028
`define DCHPG_ADDR_HOST_CTRL 16'hFFF0

// --------------------------------------------------------------------------
// field positions
// --------------------------------------------------------------------------
`define DCHPG_BIT_HOST_EN 1
`define DCHPG_BIT_FAST_EN 0
`define DCHPG_BIT_IRQ1_EN 0
`define DCHPG_BIT_IRQ2_EN 1
`define DCHPG_BIT_GATE_DIR 0
`define DCHPG_BIT_GATE_LVL 1
`define DCHPG_BIT_GATE_DATA 1

// --------------------------------------------------------------------------
// codes and reset values
// --------------------------------------------------------------------------
`define DCHPG_CMD_GATE 8'hD1
`define DCHPG_CMD_END 8'hFF
`define DCHPG_GATE_RESET 1'h1
`define DCHPG_RESP_OKAY 2'h0
`define DCHPG_RESP_SLVERR 2'h2
`define DCHPG_BYTE_ZERO 8'h00
`define DCHPG_PAD_ZERO 24'h000000

`endif

/* File: core/dchpg_pkg.sv */
// types shared by the dual channel host port gate modules
package dchpg_pkg;

  // per channel register state
  typedef struct packed {
    logic [7:0] idata;   // host-written byte
    logic [7:0] odata;   // slave-written byte
    logic cmd_flag;      // last host write was a command
    logic in_full;       // input byte not yet read by slave
    logic out_full;      // output byte not yet read by host
    logic [4:0] user;    // free status bits 7..4 and 2
  } dchpg_chan_t;

  // top level state, one register bank
  typedef struct packed {
    logic awready;
    logic wready;
    logic arready;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic aw_held;
    logic w_held;
    logic [15:0] waddr;
    logic [7:0] wbyte;
    logic wlane;
    logic host_en;
    logic fast_en;
    logic irq1_en;
    logic irq2_en;
    logic gate_dir;
    logic gate_level;
    logic armed;
    logic wr_n_d;
    logic rd_n_d;
    logic wr_ok;
    logic rd_ok;
    logic lat_ch2;
    logic lat_a0;
    logic [7:0] lat_din;
    logic [7:0] dout;
    logic dout_oe_n;
    logic gate_oe_n;
    logic irq1;
    logic irq2;
  } dchpg_state_t;

endpackage

/* File: core/dchpg_channel.sv */
// one host port channel: input, output and status registers
`timescale 1ns/1ns
`include "dchpg_consts.svh"

module dchpg_channel (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // host side events
  input wire logic host_wr,
  input wire logic host_wr_cmd,
  input wire logic [7:0] host_wr_byte,
  input wire logic host_wr_quiet,
  input wire logic host_rd_odata,
  // slave side events
  input wire logic slv_rd_idata,
  input wire logic slv_wr_odata,
  input wire logic slv_wr_status,
  input wire logic [7:0] slv_byte,
  // register views
  output dchpg_pkg::dchpg_chan_t chan
);
  import dchpg_pkg::*;

  dchpg_chan_t st;       // registered state
  dchpg_chan_t next_st;  // next state

  // ------------------------------------------------------------------------
  // next state
  // ------------------------------------------------------------------------
  // clears go first so a coinciding set wins
  always_comb begin
    next_st = st;
    if (slv_rd_idata) begin
      next_st.in_full = 1'b0;
    end
    if (host_rd_odata) begin
      next_st.out_full = 1'b0;
    end
    if (host_wr) begin
      next_st.idata = host_wr_byte;
      next_st.cmd_flag = host_wr_cmd;
      if (!host_wr_quiet) begin
        next_st.in_full = 1'b1;
      end
    end
    if (slv_wr_odata) begin
      next_st.odata = slv_byte;
      next_st.out_full = 1'b1;
    end
    if (slv_wr_status) begin
      next_st.user = {slv_byte[7:4], slv_byte[2]};
    end
  end

  // ------------------------------------------------------------------------
  // state register
  // ------------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign chan = st;

endmodule

/* File: core/dchpg_top.sv */
// dual channel host port with fast address gate decoder, axi4-lite slave
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ns
`include "dchpg_consts.svh"

module dchpg_top (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write address
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // axi4-lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read address
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // axi4-lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // host port pins
  input wire logic chan1_select_n,
  input wire logic chan2_select_n,
  input wire logic host_read_strobe_n,
  input wire logic host_write_strobe_n,
  input wire logic host_cmd_data_select,
  input wire logic [7:0] host_data_in,
  output logic [7:0] host_data_out,
  output logic host_data_oe_n,
  // gate pin
  output logic address_gate_out,
  output logic address_gate_oe_n,
  // slave interrupt requests
  output logic chan1_buffer_full_irq,
  output logic chan2_buffer_full_irq
);
  import dchpg_pkg::*;

  dchpg_state_t st;       // registered state
  dchpg_state_t next_st;  // next state
  dchpg_chan_t ch1;       // channel 1 registers
  dchpg_chan_t ch2;       // channel 2 registers

  // channel event strobes, combinational, one cycle each
  logic h1_wr;
  logic h2_wr;
  logic h1_rd;
  logic h2_rd;
  logic h1_quiet;
  logic s1_rd;
  logic s2_rd;
  logic s1_wo;
  logic s2_wo;
  logic s1_ws;
  logic s2_ws;

  // status bytes as seen by host and slave
  logic [7:0] stat1;
  logic [7:0] stat2;
  assign stat1 = {ch1.user[4:1], ch1.cmd_flag, ch1.user[0], ch1.in_full, ch1.out_full};
  assign stat2 = {ch2.user[4:1], ch2.cmd_flag, ch2.user[0], ch2.in_full, ch2.out_full};

  // ------------------------------------------------------------------------
  // channel instances
  // ------------------------------------------------------------------------
  dchpg_channel u_chan1 (
    .aclk(aclk),
    .aresetn(aresetn),
    .host_wr(h1_wr),
    .host_wr_cmd(st.lat_a0),
    .host_wr_byte(st.lat_din),
    .host_wr_quiet(h1_quiet),
    .host_rd_odata(h1_rd),
    .slv_rd_idata(s1_rd),
    .slv_wr_odata(s1_wo),
    .slv_wr_status(s1_ws),
    .slv_byte(st.wbyte),
    .chan(ch1)
  );

  dchpg_channel u_chan2 (
    .aclk(aclk),
    .aresetn(aresetn),
    .host_wr(h2_wr),
    .host_wr_cmd(st.lat_a0),
    .host_wr_byte(st.lat_din),
    .host_wr_quiet(1'b0),
    .host_rd_odata(h2_rd),
    .slv_rd_idata(s2_rd),
    .slv_wr_odata(s2_wo),
    .slv_wr_status(s2_ws),
    .slv_byte(st.wbyte),
    .chan(ch2)
  );

  // ------------------------------------------------------------------------
  // next state: bus slave, host strobes, gate decoder
  // ------------------------------------------------------------------------
  always_comb begin
    logic sel1;
    logic sel2;
    logic one_sel;
    logic wr_rise;
    logic rd_rise;
    logic do_write;
    logic hit;
    logic [7:0] rbyte;
    logic [15:0] raddr;
    next_st = st;
    sel1 = 1'b0;
    sel2 = 1'b0;
    one_sel = 1'b0;
    wr_rise = 1'b0;
    rd_rise = 1'b0;
    do_write = 1'b0;
    hit = 1'b0;
    rbyte = `DCHPG_BYTE_ZERO;
    raddr = s_axi_araddr[15:0];
    h1_wr = 1'b0;
    h2_wr = 1'b0;
    h1_rd = 1'b0;
    h2_rd = 1'b0;
    h1_quiet = 1'b0;
    s1_rd = 1'b0;
    s2_rd = 1'b0;
    s1_wo = 1'b0;
    s2_wo = 1'b0;
    s1_ws = 1'b0;
    s2_ws = 1'b0;

    // ---- host side: pins ignored unless slave mode is on
    sel1 = !chan1_select_n && chan2_select_n;
    sel2 = !chan2_select_n && chan1_select_n;
    one_sel = st.host_en && (sel1 || sel2);
    next_st.wr_n_d = host_write_strobe_n;
    next_st.rd_n_d = host_read_strobe_n;
    wr_rise = !st.wr_n_d && host_write_strobe_n;
    rd_rise = !st.rd_n_d && host_read_strobe_n;
    // hold the last address and data seen while the strobe was low
    if (!host_write_strobe_n && host_read_strobe_n && one_sel) begin
      next_st.wr_ok = 1'b1;
      next_st.lat_ch2 = sel2;
      next_st.lat_a0 = host_cmd_data_select;
      next_st.lat_din = host_data_in;
    end else if (!host_read_strobe_n && host_write_strobe_n && one_sel) begin
      next_st.rd_ok = 1'b1;
      next_st.lat_ch2 = sel2;
      next_st.lat_a0 = host_cmd_data_select;
    end
    // a strobe clash spoils the access in progress
    if (!host_write_strobe_n && !host_read_strobe_n) begin
      next_st.wr_ok = 1'b0;
      next_st.rd_ok = 1'b0;
    end
    if (wr_rise) begin
      next_st.wr_ok = 1'b0;
      h1_wr = st.wr_ok && !st.lat_ch2;
      h2_wr = st.wr_ok && st.lat_ch2;
    end
    if (rd_rise) begin
      next_st.rd_ok = 1'b0;
      h1_rd = st.rd_ok && !st.lat_ch2 && !st.lat_a0;
      h2_rd = st.rd_ok && st.lat_ch2 && !st.lat_a0;
    end

    // ---- host read data, driven only for a clean read
    next_st.dout_oe_n = 1'b1;
    next_st.dout = `DCHPG_BYTE_ZERO;
    if (one_sel && !host_read_strobe_n && host_write_strobe_n) begin
      next_st.dout_oe_n = 1'b0;
      if (sel1) begin
        next_st.dout = host_cmd_data_select ? stat1 : ch1.odata;
      end else begin
        next_st.dout = host_cmd_data_select ? stat2 : ch2.odata;
      end
    end

    // ---- fast gate decoder, channel 1 only
    if (h1_wr && st.fast_en) begin
      if (st.lat_a0) begin
        if (st.lat_din == `DCHPG_CMD_GATE) begin
          next_st.armed = 1'b1;
          h1_quiet = 1'b1;
        end else if (st.lat_din == `DCHPG_CMD_END) begin
          next_st.armed = 1'b0;
          h1_quiet = 1'b1;
        end else begin
          next_st.armed = 1'b0;
        end
      end else if (st.armed) begin
        next_st.armed = 1'b0;
        next_st.gate_level = st.lat_din[`DCHPG_BIT_GATE_DATA];
        h1_quiet = 1'b1;
      end
    end

    // ---- axi write channel: address and data in either order
    if (s_axi_awvalid && st.awready) begin
      next_st.aw_held = 1'b1;
      next_st.waddr = s_axi_awaddr[15:0];
    end
    if (s_axi_wvalid && st.wready) begin
      next_st.w_held = 1'b1;
      next_st.wbyte = s_axi_wdata[7:0];
      next_st.wlane = s_axi_wstrb[0];
    end
    do_write = st.aw_held && st.w_held && !st.bvalid;
    if (do_write) begin
      next_st.aw_held = 1'b0;
      next_st.w_held = 1'b0;
      next_st.bvalid = 1'b1;
      hit = 1'b1;
      case (st.waddr)
        `DCHPG_ADDR_SYS_CTRL: begin
          if (st.wlane) begin
            next_st.host_en = st.wbyte[`DCHPG_BIT_HOST_EN];
          end
        end
        `DCHPG_ADDR_HOST_CTRL: begin
          if (st.wlane) begin
            next_st.fast_en = st.wbyte[`DCHPG_BIT_FAST_EN];
          end
        end
        `DCHPG_ADDR_IRQ_EN: begin
          if (st.wlane) begin
            next_st.irq1_en = st.wbyte[`DCHPG_BIT_IRQ1_EN];
            next_st.irq2_en = st.wbyte[`DCHPG_BIT_IRQ2_EN];
          end
        end
        `DCHPG_ADDR_GATE_PORT: begin
          // firmware path for regular gating; the decoder overrides below
          if (st.wlane) begin
            next_st.gate_dir = st.wbyte[`DCHPG_BIT_GATE_DIR];
            next_st.gate_level = st.wbyte[`DCHPG_BIT_GATE_LVL];
          end
        end
        `DCHPG_ADDR_C1_ODATA: s1_wo = st.wlane;
        `DCHPG_ADDR_C2_ODATA: s2_wo = st.wlane;
        `DCHPG_ADDR_C1_STATUS: s1_ws = st.wlane;
        `DCHPG_ADDR_C2_STATUS: s2_ws = st.wlane;
        `DCHPG_ADDR_C1_IDATA: hit = 1'b1;
        `DCHPG_ADDR_C2_IDATA: hit = 1'b1;
        default: hit = 1'b0;
      endcase
      next_st.bresp = hit ? `DCHPG_RESP_OKAY : `DCHPG_RESP_SLVERR;
      // hardware gating has the last word on a same cycle collision
      if (h1_wr && st.fast_en && !st.lat_a0 && st.armed) begin
        next_st.gate_level = st.lat_din[`DCHPG_BIT_GATE_DATA];
      end
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    next_st.awready = !next_st.aw_held && !next_st.bvalid;
    next_st.wready = !next_st.w_held && !next_st.bvalid;

    // ---- axi read channel: one cycle from address to data
    if (s_axi_arvalid && st.arready) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = `DCHPG_RESP_OKAY;
      case (raddr)
        `DCHPG_ADDR_SYS_CTRL: rbyte[`DCHPG_BIT_HOST_EN] = st.host_en;
        `DCHPG_ADDR_HOST_CTRL: rbyte[`DCHPG_BIT_FAST_EN] = st.fast_en;
        `DCHPG_ADDR_IRQ_EN: begin
          rbyte[`DCHPG_BIT_IRQ1_EN] = st.irq1_en;
          rbyte[`DCHPG_BIT_IRQ2_EN] = st.irq2_en;
        end
        `DCHPG_ADDR_GATE_PORT: begin
          rbyte[`DCHPG_BIT_GATE_DIR] = st.gate_dir;
          rbyte[`DCHPG_BIT_GATE_LVL] = st.gate_level;
        end
        `DCHPG_ADDR_C1_IDATA: begin
          rbyte = ch1.idata;
          s1_rd = 1'b1;
        end
        `DCHPG_ADDR_C2_IDATA: begin
          rbyte = ch2.idata;
          s2_rd = 1'b1;
        end
        `DCHPG_ADDR_C1_ODATA: rbyte = ch1.odata;
        `DCHPG_ADDR_C2_ODATA: rbyte = ch2.odata;
        `DCHPG_ADDR_C1_STATUS: rbyte = stat1;
        `DCHPG_ADDR_C2_STATUS: rbyte = stat2;
        default: next_st.rresp = `DCHPG_RESP_SLVERR;
      endcase
      next_st.rdata = {`DCHPG_PAD_ZERO, rbyte};
    end
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    next_st.arready = !next_st.rvalid;

    // ---- pins driven from the registered state
    next_st.gate_oe_n = !next_st.gate_dir;
    next_st.irq1 = next_st.irq1_en && ch1.in_full;
    next_st.irq2 = next_st.irq2_en && ch2.in_full;
  end

  // ------------------------------------------------------------------------
  // state register
  // ------------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st <= '0;
      st.awready <= 1'b1;
      st.wready <= 1'b1;
      st.arready <= 1'b1;
      st.wr_n_d <= 1'b1;
      st.rd_n_d <= 1'b1;
      st.dout_oe_n <= 1'b1;
      st.gate_oe_n <= 1'b1;
      st.gate_level <= `DCHPG_GATE_RESET;
    end else begin
      st <= next_st;
    end
  end

  // ------------------------------------------------------------------------
  // outputs, all straight from the state register
  // ------------------------------------------------------------------------
  assign s_axi_awready = st.awready;
  assign s_axi_wready = st.wready;
  assign s_axi_bresp = st.bresp;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_arready = st.arready;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;
  assign s_axi_rvalid = st.rvalid;
  assign host_data_out = st.dout;
  assign host_data_oe_n = st.dout_oe_n;
  assign address_gate_out = st.gate_level;
  assign address_gate_oe_n = st.gate_oe_n;
  assign chan1_buffer_full_irq = st.irq1;
  assign chan2_buffer_full_irq = st.irq2;

endmodule

/* File: tb/dchpg_checker.sv */
// port checker for the dual channel host port gate
`timescale 1ns/1ns
module dchpg_checker (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite answers
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // host port pins
  input wire logic chan1_select_n,
  input wire logic chan2_select_n,
  input wire logic host_read_strobe_n,
  input wire logic host_write_strobe_n,
  input wire logic host_data_oe_n,
  // gate and interrupts
  input wire logic address_gate_out,
  input wire logic chan1_buffer_full_irq,
  input wire logic chan2_buffer_full_irq
);
  logic [5:0] wr1_hist; // recent channel 1 host write samples

  // ------------------------------------------------------------
  // helper history
  // ------------------------------------------------------------
  // a window, since capture lags the strobe by a few edges
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr1_hist <= 6'h00;
    end else begin
      wr1_hist <= {wr1_hist[4:0], !chan1_select_n && !host_write_strobe_n};
    end
  end

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  // read strobe held with exactly one channel selected
  sequence s_rd_held;
    (!host_read_strobe_n && host_write_strobe_n && (chan1_select_n != chan2_select_n))[*2];
  endsequence

  AST_READ_DRIVES:
    assert property (s_rd_held |-> !host_data_oe_n)
    else $error("host bus not driven during read");
  AST_IDLE_NO_DRIVE:
    assert property (host_read_strobe_n |=> host_data_oe_n)
    else $error("host bus driven without read strobe");
  AST_BOTH_NO_DRIVE:
    assert property (!host_read_strobe_n && !host_write_strobe_n |=> host_data_oe_n)
    else $error("host bus driven on overlapped strobes");
  AST_GATE_CAUSE:
    assert property ($changed(address_gate_out) |->
      $rose(s_axi_bvalid) || (wr1_hist != 6'h00) || !$past(aresetn))
    else $error("gate moved without channel 1 write");
  AST_IRQ1_RISE:
    assert property ($rose(chan1_buffer_full_irq) |->
      s_axi_bvalid || (wr1_hist != 6'h00))
    else $error("irq1 rose without cause");
  AST_IRQ1_FALL:
    assert property ($fell(chan1_buffer_full_irq) |->
      $past(s_axi_rvalid) || s_axi_bvalid || !$past(aresetn))
    else $error("irq1 fell without slave access");
  AST_IRQ2_FALL:
    assert property ($fell(chan2_buffer_full_irq) |->
      $past(s_axi_rvalid) || s_axi_bvalid || !$past(aresetn))
    else $error("irq2 fell without slave access");
  AST_R_LATENCY:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_B_ONE:
    assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
endmodule

bind dchpg_top dchpg_checker i_chk (.*);

/* File: tb/dchpg_host_model.sv */
// host processor model driving the parallel host port pins
`timescale 1ns/1ns
module dchpg_host_model (
  // clock
  input wire logic aclk,
  // host port pins
  output logic chan1_select_n,
  output logic chan2_select_n,
  output logic host_read_strobe_n,
  output logic host_write_strobe_n,
  output logic host_cmd_data_select,
  output logic [7:0] host_data_in,
  input wire logic [7:0] host_data_out,
  input wire logic host_data_oe_n
);
  int hold = 2; // strobe low time, raise for a slow host

  // idle pins at time zero
  initial begin
    {chan1_select_n, chan2_select_n, host_read_strobe_n, host_write_strobe_n} = 4'hF;
    {host_cmd_data_select, host_data_in} = 9'h000;
  end

  // ------------------------------------------------------------
  // host cycles
  // ------------------------------------------------------------
  // deselect; inverted lines so a stale value never passes
  task automatic release_bus(input logic a0);
    chan1_select_n <= 1'h1;
    chan2_select_n <= 1'h1;
    host_cmd_data_select <= ~a0;
  endtask

  // one write; both overlaps the strobes only when a test asks
  task automatic write(input int ch, input logic a0, input logic [7:0] b, input bit both);
    @(posedge aclk);
    chan1_select_n <= (ch != 1);
    chan2_select_n <= (ch != 2);
    host_cmd_data_select <= a0;
    host_data_in <= b;
    host_write_strobe_n <= 1'h0;
    host_read_strobe_n <= !both;
    repeat (hold) @(posedge aclk);
    host_write_strobe_n <= 1'h1;
    host_read_strobe_n <= 1'h1;
    @(posedge aclk);
    release_bus(a0);
    host_data_in <= ~b;
  endtask

  // one read; returns drive enable and byte seen
  task automatic read(input int ch, input logic a0, output logic [8:0] v);
    @(posedge aclk);
    chan1_select_n <= (ch != 1);
    chan2_select_n <= (ch != 2);
    host_cmd_data_select <= a0;
    host_read_strobe_n <= 1'h0;
    repeat (hold + 1) @(posedge aclk);
    v = {host_data_oe_n, host_data_out};
    host_read_strobe_n <= 1'h1;
    @(posedge aclk);
    release_bus(a0);
  endtask
endmodule

/* File: tb/dchpg_tb.sv */
// self-checking bench for the dual channel host port gate
`timescale 1ns/1ns
`include "dchpg_consts.svh"
module dchpg_tb;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0, rdata, rv;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid, s1_n, s2_n, rd_n, wr_n, a0, oe_n;
  logic gate, gate_oe_n, irq1, irq2;
  logic [1:0] bresp, rresp, last_b, last_r;
  logic [7:0] hdin, hdout;
  logic [8:0] hv;
  int fails = 0;
  int total_checks = 0;
  // fast gate steps, packed {channel[1:0], select, byte[7:0], gate, channel 1 full flag}
  localparam logic [12:0] FSEQ [16] = '{
    13'h0F46, 13'h0800, 13'h0FFC, 13'h0F44, 13'h080A, 13'h0F46, 13'h0D57, 13'h0803,
    13'h0F46, 13'h0F46, 13'h0BF4, 13'h1744, 13'h1008, 13'h0F44, 13'h081A, 13'h0EAB};

  always #5 aclk = ~aclk;

  dchpg_top i_dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .chan1_select_n(s1_n), .chan2_select_n(s2_n), .host_read_strobe_n(rd_n),
    .host_write_strobe_n(wr_n), .host_cmd_data_select(a0), .host_data_in(hdin),
    .host_data_out(hdout), .host_data_oe_n(oe_n), .address_gate_out(gate),
    .address_gate_oe_n(gate_oe_n), .chan1_buffer_full_irq(irq1),
    .chan2_buffer_full_irq(irq2));

  dchpg_host_model i_host (.aclk(aclk), .chan1_select_n(s1_n), .chan2_select_n(s2_n),
    .host_read_strobe_n(rd_n), .host_write_strobe_n(wr_n), .host_cmd_data_select(a0),
    .host_data_in(hdin), .host_data_out(hdout), .host_data_oe_n(oe_n));

  // ------------------------------------------------------------
  // bus tasks and compare
  // ------------------------------------------------------------
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", nm, exp, got);
      fails++;
    end
  endtask

  // address and data offered together, each dropped once taken
  task axi_wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge aclk);
    awaddr <= {16'h0000, a};
    wdata <= {24'h000000, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
    end while (!bvalid);
    last_b = bresp;
    bready <= 1'h0;
  endtask

  task axi_rd(input logic [15:0] a);
    @(posedge aclk);
    araddr <= {16'h0000, a};
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'h0;
    end while (!rvalid);
    rv = rdata;
    last_r = rresp;
    rready <= 1'h0;
  endtask

  task rd_chk(input string nm, input logic [15:0] a, input logic [31:0] exp);
    axi_rd(a);
    chk(nm, exp, rv);
  endtask

  // let pin updates land
  task settle;
    repeat (4) @(posedge aclk);
    #1;
  endtask

  task tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    int ch;
    logic [15:0] base;
    logic [12:0] e;
    repeat (10) @(posedge aclk);
    aresetn <= 1'h1;
    // reset values, port still off
    rd_chk("sys_ctrl", `DCHPG_ADDR_SYS_CTRL, 32'h0);
    rd_chk("host_ctrl", `DCHPG_ADDR_HOST_CTRL, 32'h0);
    chk("gate", 32'h1, gate);
    chk("gate_oe_n", 32'h1, gate_oe_n);
    i_host.write(1, 1'h0, 8'h5A, 0);
    rd_chk("status off", `DCHPG_ADDR_C1_STATUS, 32'h0);
    $display("test reset done");
    axi_wr(`DCHPG_ADDR_SYS_CTRL, 8'h02);
    axi_wr(`DCHPG_ADDR_IRQ_EN, 8'h03);
    for (ch = 1; ch <= 2; ch++) begin
      base = {ch[11:0], 4'h0};
      i_host.write(ch, 1'h0, 8'hA0 + ch[7:0], 0);
      rd_chk("status full", base + 16'h0008, 32'h02);
      settle;
      chk("irq", {30'h0, ch[1:0]}, {irq2, irq1});
      rd_chk("idata", base, 32'hA0 + ch);
      rd_chk("status clear", base + 16'h0008, 32'h0);
      settle;
      chk("irq clear", 32'h0, {irq2, irq1});
      i_host.write(ch, 1'h1, 8'h3C, 0);
      rd_chk("status cmd", base + 16'h0008, 32'h0A);
      rd_chk("cmd byte", base, 32'h3C);
      axi_wr(base + 16'h0004, 8'hC0 + ch[7:0]);
      rd_chk("out full", base + 16'h0008, 32'h09);
      i_host.read(ch, 1'h0, hv);
      chk("host data", 32'hC0 + ch, hv);
      i_host.read(ch, 1'h1, hv);
      chk("host status", 32'h08, hv);
      i_host.write(ch, 1'h0, 8'hEE, 1);
      rd_chk("overlap", base + 16'h0008, 32'h08);
      $display("test channel %0d done", ch);
    end
    // masked interrupt, then unmasked
    axi_wr(`DCHPG_ADDR_IRQ_EN, 8'h00);
    i_host.write(1, 1'h0, 8'h11, 0);
    settle;
    chk("irq masked", 32'h0, irq1);
    axi_wr(`DCHPG_ADDR_IRQ_EN, 8'h01);
    settle;
    chk("irq unmasked", 32'h1, irq1);
    rd_chk("idata", `DCHPG_ADDR_C1_IDATA, 32'h11);
    $display("test irq mask done");
    // fast gate with a slow host
    i_host.hold = 4;
    axi_wr(`DCHPG_ADDR_GATE_PORT, 8'h03);
    axi_wr(`DCHPG_ADDR_HOST_CTRL, 8'h01);
    rd_chk("host_ctrl", `DCHPG_ADDR_HOST_CTRL, 32'h1);
    settle;
    chk("gate_oe_n", 32'h0, gate_oe_n);
    chk("gate start", 32'h1, gate);
    foreach (FSEQ[i]) begin
      e = FSEQ[i];
      i_host.write(int'(e[12:11]), e[10], e[9:2], 0);
      axi_rd(`DCHPG_ADDR_C1_STATUS);
      chk("flag", {31'h0, e[0]}, rv[1]);
      if (rv[1] === 1'h1) axi_rd(`DCHPG_ADDR_C1_IDATA);
      settle;
      chk("gate", {31'h0, e[1]}, gate);
    end
    $display("test fast gate done");
    // fast gate off: firmware copies the bit
    axi_wr(`DCHPG_ADDR_HOST_CTRL, 8'h00);
    i_host.write(1, 1'h1, 8'hD1, 0);
    i_host.write(1, 1'h0, 8'h00, 0);
    settle;
    chk("gate soft", 32'h1, gate);
    rd_chk("firmware byte", `DCHPG_ADDR_C1_IDATA, 32'h00);
    axi_wr(`DCHPG_ADDR_GATE_PORT, {6'h00, rv[1], 1'h1});
    settle;
    chk("gate copy", 32'h0, gate);
    $display("test slow gate done");
    // unmapped places answer with an error
    axi_rd(16'h0030);
    chk("rresp", 32'h2, last_r);
    axi_wr(16'h0034, 8'h00);
    chk("bresp", 32'h2, last_b);
    $display("test unmapped done");
    tally_and_finish;
  end

  // hang guard, well past the run length
  initial begin
    repeat (30000) @(posedge aclk);
    fails++;
    tally_and_finish;
  end
endmodule
